// file: rtl/sacf_crc16.sv
// Bytewise 16-bit CRC register, least significant bit first
`timescale 1ns/1ps
`include "sacf_defs.svh"
module sacf_crc16
  import sacf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  // Result
  output logic [15:0] crc
);

  sacf_crc_regs_t q;
  sacf_crc_regs_t d;
  logic [15:0] chain [0:8];

  assign chain[0] = q.crc;

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic fb;
      assign fb = chain[b][0] ^ data[b];
      assign chain[b + 1] = fb ? ((chain[b] >> 1) ^ `SACF_CRC16_POLY) : (chain[b] >> 1);
    end
  endgenerate

  always_comb begin
    d = q;
    if (clr) begin
      d.crc = `SACF_CRC16_INIT;
    end else if (en) begin
      d.crc = chain[8];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{crc: `SACF_CRC16_INIT};
    end else begin
      q <= d;
    end
  end

  assign crc = q.crc;

endmodule

// file: rtl/sacf_defs.svh
// Constants of the secure authenticator command framer
`ifndef SACF_DEFS_SVH
`define SACF_DEFS_SVH

`define SACF_CMD_START 8'h66
`define SACF_FC_SIGN_PAGE 8'ha5
`define SACF_FC_AUTH_WRITE 8'h89
`define SACF_FC_CERT_CHECK 8'h59
`define SACF_FC_READ_PUBKEY 8'hcb
`define SACF_FC_PROTECT 8'hc3
`define SACF_CRC16_POLY 16'ha001
`define SACF_CRC16_INIT 16'h0000
`define SACF_MAX_DATA 8'hfe
`define SACF_MEM_AW 8

`endif

// file: rtl/sacf_mem.sv
// Byte memory with registered read data
`timescale 1ns/1ps
`include "sacf_defs.svh"
module sacf_mem
  import sacf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Memory ports
  sacf_mem_if.mem port
);

  logic [7:0] store [0:(1 << `SACF_MEM_AW) - 1];
  logic [7:0] rdata_q;

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= store[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule

// file: rtl/sacf_mem_if.sv
// Port bundle of a byte memory
`timescale 1ns/1ps
interface sacf_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;

  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rtl/sacf_pkg.sv
// Types of the secure authenticator command framer
package sacf_pkg;

  typedef enum logic [4:0] {
    SACF_WAIT_RST = 5'h00,
    SACF_WAIT_ROM = 5'h01,
    SACF_START = 5'h02,
    SACF_LEN = 5'h03,
    SACF_CODE = 5'h04,
    SACF_PARAM = 5'h05,
    SACF_CRC1_LO = 5'h06,
    SACF_CRC1_HI = 5'h07,
    SACF_RELEASE = 5'h08,
    SACF_BUSY = 5'h09,
    SACF_DUMMY = 5'h0a,
    SACF_TX_LEN = 5'h0b,
    SACF_TX_RES = 5'h0c,
    SACF_TX_DATA = 5'h0d,
    SACF_CRC2_LO = 5'h0e,
    SACF_CRC2_HI = 5'h0f,
    SACF_HALT = 5'h10
  } sacf_state_t;

  typedef enum logic [2:0] {
    SACF_K_NONE = 3'h0,
    SACF_K_SIGN_PAGE = 3'h1,
    SACF_K_AUTH_WRITE = 3'h2,
    SACF_K_CERT_CHECK = 3'h3,
    SACF_K_READ_PUBKEY = 3'h4,
    SACF_K_PROTECT = 3'h5,
    SACF_K_OTHER = 3'h6
  } sacf_kind_t;

  typedef struct packed {
    sacf_state_t st;
    logic rst_seen;
    logic armed;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [7:0] code;
    sacf_kind_t kind;
    logic cmd_start;
    logic spu;
    logic [7:0] res;
    logic [7:0] dlen;
    logic [7:0] idx;
    logic pend;
    logic tx_valid;
    logic [7:0] tx_data;
    logic frame_err;
    logic done;
  } sacf_regs_t;

  typedef struct packed {
    logic [15:0] crc;
  } sacf_crc_regs_t;

endpackage

// file: rtl/sacf_top.sv
// Command framer of a single-wire secure authenticator, byte level
`timescale 1ns/1ps
`include "sacf_defs.svh"
module sacf_top
  import sacf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Bus events from the slot and ROM layers
  input wire logic bus_reset,
  input wire logic rom_done,
  // Received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Bytes to send
  input wire logic tx_take,
  output logic tx_valid,
  output logic [7:0] tx_data,
  // Command towards the function engine
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [2:0] cmd_kind,
  output logic [7:0] param_len,
  input wire logic [7:0] param_raddr,
  output logic [7:0] param_rdata,
  // Answer from the function engine
  input wire logic rsp_done,
  input wire logic [7:0] rsp_result,
  input wire logic [7:0] rsp_len,
  input wire logic rsp_we,
  input wire logic [7:0] rsp_waddr,
  input wire logic [7:0] rsp_wdata,
  // Status
  output logic spu_active,
  output logic armed,
  output logic frame_err,
  output logic frame_done
);

  sacf_regs_t q;
  sacf_regs_t d;
  logic [15:0] crc;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_data;
  logic take;

  sacf_mem_if param_bus ();
  sacf_mem_if rsp_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Memories and CRC

  sacf_mem u_param_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .port(param_bus.mem)
  );

  sacf_mem u_rsp_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .port(rsp_bus.mem)
  );

  assign param_bus.we = (q.st == SACF_PARAM) && rx_valid;
  assign param_bus.waddr = q.cnt;
  assign param_bus.wdata = rx_data;
  assign param_bus.raddr = param_raddr;
  assign param_rdata = param_bus.rdata;

  assign rsp_bus.we = rsp_we;
  assign rsp_bus.waddr = rsp_waddr;
  assign rsp_bus.wdata = rsp_wdata;
  assign rsp_bus.raddr = q.idx;

  sacf_crc16 u_crc (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clr(crc_clr),
    .en(crc_en),
    .data(crc_data),
    .crc(crc)
  );

  assign take = q.tx_valid && tx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  function automatic sacf_kind_t decode(input logic [7:0] code);
    sacf_kind_t k;
    k = SACF_K_OTHER;
    unique case (code)
      `SACF_FC_SIGN_PAGE: k = SACF_K_SIGN_PAGE;
      `SACF_FC_AUTH_WRITE: k = SACF_K_AUTH_WRITE;
      `SACF_FC_CERT_CHECK: k = SACF_K_CERT_CHECK;
      `SACF_FC_READ_PUBKEY: k = SACF_K_READ_PUBKEY;
      `SACF_FC_PROTECT: k = SACF_K_PROTECT;
      default: k = SACF_K_OTHER;
    endcase
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Framing sequence

  always_comb begin
    d = q;
    d.cmd_start = 1'b0;
    d.done = 1'b0;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_data = rx_data;
    unique case (q.st)
      SACF_WAIT_RST: begin
        d.st = SACF_WAIT_RST;
      end
      SACF_WAIT_ROM: begin
        if (rom_done) begin
          d.armed = 1'b1;
          d.st = SACF_START;
        end
      end
      SACF_START: begin
        if (rx_valid) begin
          if (rx_data == `SACF_CMD_START) begin
            crc_clr = 1'b1;
            d.st = SACF_LEN;
          end else begin
            d.frame_err = 1'b1;
            d.st = SACF_HALT;
          end
        end
      end
      SACF_LEN: begin
        if (rx_valid) begin
          crc_en = 1'b1;
          d.len = rx_data;
          d.cnt = 8'h00;
          if (rx_data == 8'h00) begin
            d.frame_err = 1'b1;
            d.st = SACF_HALT;
          end else begin
            d.st = SACF_CODE;
          end
        end
      end
      SACF_CODE: begin
        if (rx_valid) begin
          crc_en = 1'b1;
          d.code = rx_data;
          d.kind = decode(rx_data);
          d.st = (q.len == 8'h01) ? SACF_CRC1_LO : SACF_PARAM;
        end
      end
      SACF_PARAM: begin
        if (rx_valid) begin
          crc_en = 1'b1;
          d.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h02 == q.len) begin
            d.st = SACF_CRC1_LO;
          end
        end
      end
      SACF_CRC1_LO: begin
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = ~crc[7:0];
        end else if (take) begin
          d.tx_valid = 1'b0;
          d.st = SACF_CRC1_HI;
        end
      end
      SACF_CRC1_HI: begin
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = ~crc[15:8];
        end else if (take) begin
          d.tx_valid = 1'b0;
          d.st = SACF_RELEASE;
        end
      end
      SACF_RELEASE: begin
        if (rx_valid) begin
          d.cmd_start = 1'b1;
          d.spu = 1'b1;
          d.st = SACF_BUSY;
        end
      end
      SACF_BUSY: begin
        if (rsp_done) begin
          d.spu = 1'b0;
          d.res = rsp_result;
          d.dlen = (rsp_len > `SACF_MAX_DATA) ? `SACF_MAX_DATA : rsp_len;
          d.st = SACF_DUMMY;
        end
      end
      SACF_DUMMY: begin
        if (rx_valid) begin
          crc_clr = 1'b1;
          d.st = SACF_TX_LEN;
        end
      end
      SACF_TX_LEN: begin
        crc_data = q.tx_data;
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = q.dlen + 8'h01;
        end else if (take) begin
          crc_en = 1'b1;
          d.tx_valid = 1'b0;
          d.st = SACF_TX_RES;
        end
      end
      SACF_TX_RES: begin
        crc_data = q.tx_data;
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = q.res;
        end else if (take) begin
          crc_en = 1'b1;
          d.tx_valid = 1'b0;
          d.idx = 8'h00;
          d.pend = 1'b0;
          d.st = (q.dlen == 8'h00) ? SACF_CRC2_LO : SACF_TX_DATA;
        end
      end
      SACF_TX_DATA: begin
        crc_data = q.tx_data;
        if (!q.tx_valid) begin
          // One cycle for the read data to follow the index
          if (!q.pend) begin
            d.pend = 1'b1;
          end else begin
            d.tx_valid = 1'b1;
            d.tx_data = rsp_bus.rdata;
          end
        end else if (take) begin
          crc_en = 1'b1;
          d.tx_valid = 1'b0;
          d.pend = 1'b0;
          d.idx = q.idx + 8'h01;
          if (q.idx + 8'h01 == q.dlen) begin
            d.st = SACF_CRC2_LO;
          end
        end
      end
      SACF_CRC2_LO: begin
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = ~crc[7:0];
        end else if (take) begin
          d.tx_valid = 1'b0;
          d.st = SACF_CRC2_HI;
        end
      end
      SACF_CRC2_HI: begin
        if (!q.tx_valid) begin
          d.tx_valid = 1'b1;
          d.tx_data = ~crc[15:8];
        end else if (take) begin
          d.tx_valid = 1'b0;
          d.done = 1'b1;
          d.armed = 1'b0;
          d.st = SACF_HALT;
        end
      end
      SACF_HALT: begin
        d.st = SACF_HALT;
      end
      default: begin
        d.st = SACF_HALT;
      end
    endcase
    // A bus reset aborts any frame and demands a fresh ROM command
    if (bus_reset) begin
      d.st = SACF_WAIT_ROM;
      d.armed = 1'b0;
      d.rst_seen = 1'b1;
      d.spu = 1'b0;
      d.tx_valid = 1'b0;
      d.pend = 1'b0;
      d.frame_err = 1'b0;
      d.cmd_start = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: SACF_WAIT_RST, kind: SACF_K_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign cmd_start = q.cmd_start;
  assign cmd_code = q.code;
  assign cmd_kind = q.kind;
  assign param_len = q.cnt;
  assign spu_active = q.spu;
  assign armed = q.armed;
  assign frame_err = q.frame_err;
  assign frame_done = q.done;

endmodule

// file: verification/sacf_host.sv
// Bus master model at byte level
`timescale 1ns/1ps
module sacf_host (
  // Clock
  input logic ref_clk,
  // Byte stream
  input logic tx_valid,
  input logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_take
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_take = 1'b0;
  end
  // Idle data line shows the inverse of the last byte
  task send(input logic [7:0] b);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
  // Waits for a byte, then takes it after w idle cycles
  task recv(output logic [7:0] b, input int w);
    int i;
    for (i = 0; i < 20 && tx_valid !== 1'b1; i++) @(negedge ref_clk);
    repeat (w) @(negedge ref_clk);
    b = tx_data;
    tx_take = 1'b1;
    @(negedge ref_clk);
    tx_take = 1'b0;
  endtask
endmodule

// file: verification/sacf_props.sv
// Protocol checker of the command framer
`timescale 1ns/1ps
module sacf_chk (
  // Clock and reset
  input logic ref_clk,
  input logic arst_n,
  // Inputs
  input logic bus_reset,
  input logic rsp_done,
  input logic tx_take,
  // Outputs
  input logic tx_valid,
  input logic [7:0] tx_data,
  input logic cmd_start,
  input logic spu_active,
  input logic armed,
  input logic frame_err,
  input logic frame_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_tx_hold: assert property (
    tx_valid && !tx_take && !bus_reset |=> tx_valid && $stable(tx_data))
    else $error("tx byte not held");
  chk_tx_drop: assert property (
    tx_valid && tx_take && !bus_reset |=> !tx_valid) else $error("tx byte kept");
  chk_tx_armed: assert property (
    tx_valid |-> armed) else $error("tx while not armed");
  chk_start_pulse: assert property (
    cmd_start |=> !cmd_start) else $error("cmd_start too long");
  chk_start_spu: assert property (
    cmd_start |-> spu_active) else $error("no pullup at start");
  chk_spu_quiet: assert property (
    spu_active |-> !tx_valid) else $error("tx during pullup");
  chk_spu_end: assert property (
    spu_active && rsp_done && !bus_reset |-> ##[1:2] !spu_active)
    else $error("pullup not ended");
  chk_done_cause: assert property (
    frame_done |-> $past(tx_take) && !armed && !tx_valid)
    else $error("bad frame end");
  chk_err_sticky: assert property (
    frame_err && !bus_reset |=> frame_err) else $error("error flag lost");
  cover property (cmd_start);
  cover property (frame_done);
  cover property (frame_err);
endmodule

// file: verification/tb_top.sv
// Self-checking bench of the command framer
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic bus_reset = 1'b0;
  logic rom_done = 1'b0;
  logic rx_valid, tx_take, tx_valid, cmd_start, spu_active, armed, frame_err, frame_done;
  logic [7:0] rx_data, tx_data, cmd_code, param_len, param_rdata;
  logic [2:0] cmd_kind;
  logic [7:0] param_raddr = 8'h00;
  logic rsp_done = 1'b0;
  logic rsp_we = 1'b0;
  logic [7:0] rsp_result = 8'h00;
  logic [7:0] rsp_len = 8'h00;
  logic [7:0] rsp_waddr = 8'h00;
  logic [7:0] rsp_wdata = 8'h00;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  sacf_top dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .bus_reset(bus_reset),
    .rom_done(rom_done),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_take(tx_take),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .cmd_start(cmd_start),
    .cmd_code(cmd_code),
    .cmd_kind(cmd_kind),
    .param_len(param_len),
    .param_raddr(param_raddr),
    .param_rdata(param_rdata),
    .rsp_done(rsp_done),
    .rsp_result(rsp_result),
    .rsp_len(rsp_len),
    .rsp_we(rsp_we),
    .rsp_waddr(rsp_waddr),
    .rsp_wdata(rsp_wdata),
    .spu_active(spu_active),
    .armed(armed),
    .frame_err(frame_err),
    .frame_done(frame_done)
  );
  sacf_host host (
    .ref_clk(ref_clk),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_take(tx_take)
  );
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // Reflected CRC, sent inverted
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return ~c;
  endfunction
  task arm(input logic rom);
    @(negedge ref_clk) bus_reset = 1'b1;
    @(negedge ref_clk) bus_reset = 1'b0;
    rom_done = rom;
    @(negedge ref_clk) rom_done = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_no_rom;
    arm(1'b0);
    host.send(8'h66);
    host.send(8'h01);
    host.send(8'ha5);
    repeat (4) @(negedge ref_clk);
    chk("tx_valid", 8'h00, {7'h00, tx_valid});
    chk("armed", 8'h00, {7'h00, armed});
  endtask
  task t_bad_start;
    arm(1'b1);
    host.send(8'h55);
    repeat (2) @(negedge ref_clk);
    chk("frame_err", 8'h01, {7'h00, frame_err});
    arm(1'b1);
    chk("frame_err", 8'h00, {7'h00, frame_err});
    host.send(8'h66);
    host.send(8'h00);
    repeat (2) @(negedge ref_clk);
    chk("frame_err", 8'h01, {7'h00, frame_err});
  endtask
  task t_frame(input logic [7:0] code, input logic [2:0] kind, input int np, input int nd,
    input int w);
    logic [7:0] q[$];
    logic [7:0] b;
    logic [15:0] c;
    int i;
    arm(1'b1);
    chk("armed", 8'h01, {7'h00, armed});
    host.send(8'h66);
    q = {8'(np + 1), code};
    for (i = 0; i < np; i++) q.push_back(8'h10 + 8'(i));
    foreach (q[k]) host.send(q[k]);
    c = crc(q);
    host.recv(b, w);
    chk("crc1 lo", c[7:0], b);
    host.recv(b, 0);
    chk("crc1 hi", c[15:8], b);
    chk("cmd_kind", {5'h00, kind}, {5'h00, cmd_kind});
    chk("cmd_code", code, cmd_code);
    chk("param_len", 8'(np), param_len);
    host.send(8'h00);
    for (i = 0; i < 20 && cmd_start !== 1'b1; i++) @(negedge ref_clk);
    chk("cmd_start", 8'h01, {7'h00, cmd_start});
    chk("spu_active", 8'h01, {7'h00, spu_active});
    param_raddr = (np > 0) ? 8'(np - 1) : 8'h00;
    for (i = 0; i < nd; i++) begin
      @(negedge ref_clk);
      rsp_we = 1'b1;
      rsp_waddr = 8'(i);
      rsp_wdata = 8'h80 + 8'(i);
    end
    @(negedge ref_clk);
    rsp_we = 1'b0;
    if (np > 0) chk("param_rdata", 8'h10 + 8'(np - 1), param_rdata);
    rsp_result = ~code;
    rsp_len = 8'(nd);
    rsp_done = 1'b1;
    @(negedge ref_clk) rsp_done = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("spu_active", 8'h00, {7'h00, spu_active});
    host.send(8'h00);
    q = {8'(nd + 1), rsp_result};
    for (i = 0; i < nd; i++) q.push_back(8'h80 + 8'(i));
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[k]) begin
      host.recv(b, 0);
      chk("tx byte", q[k], b);
    end
    chk("frame_done", 8'h01, {7'h00, frame_done});
    chk("armed", 8'h00, {7'h00, armed});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    t_no_rom();
    t_bad_start();
    t_frame(8'ha5, 3'h1, 1, 0, 0);
    t_frame(8'h89, 3'h2, 3, 2, 3);
    t_frame(8'h59, 3'h3, 2, 1, 0);
    t_frame(8'hcb, 3'h4, 1, 4, 0);
    t_frame(8'hc3, 3'h5, 2, 0, 1);
    t_frame(8'h12, 3'h6, 1, 1, 0);
    t_frame(8'h33, 3'h6, 0, 2, 0);
    results();
  end
endmodule
bind sacf_top sacf_chk u_chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .bus_reset(bus_reset),
  .rsp_done(rsp_done),
  .tx_take(tx_take),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .cmd_start(cmd_start),
  .spu_active(spu_active),
  .armed(armed),
  .frame_err(frame_err),
  .frame_done(frame_done)
);
